// ==== hw/adcps_map.svh ====
`ifndef ADCPS_MAP_SVH
`define ADCPS_MAP_SVH

// ----------------------------------------------------------------
// Configuration word layout
// ----------------------------------------------------------------
`define ADCPS_CFG_W        8
`define ADCPS_WL_HI_BIT    1
`define ADCPS_WL_LO_BIT    0
`define ADCPS_WL_SHDN      2'h1

// ----------------------------------------------------------------
// Shift-clock counts
// ----------------------------------------------------------------
`define ADCPS_CFG_DONE_CNT 5'h08
`define ADCPS_SHDN_EDGE    5'h0A
`define ADCPS_CNT_MAX      5'h1F

// ----------------------------------------------------------------
// Dummy conversion length in core clock cycles
// ----------------------------------------------------------------
`define ADCPS_DUMMY_CYC    8'h40

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define ADCPS_CNT_RST      5'h00
`define ADCPS_CFG_RST      8'h00

`endif

// ==== hw/adcps_pkg.sv ====
package adcps_pkg;

  // Gray codes along run -> dummy -> sleep
  typedef enum logic [1:0] {
    st_run   = 2'b00,
    st_dummy = 2'b01,
    st_sleep = 2'b11
  } adcps_state_t;

  // Signals that cross from the pins / shift-clock domain
  typedef struct packed {
    logic cs_n;
    logic act_tog;
    logic sd_tog;
  } adcps_link_t;

  // Status seen by the converter core
  typedef struct packed {
    logic power_dn;
    logic dummy_busy;
    logic conv_req;
  } adcps_stat_t;

endpackage

// ==== hw/adcps_sync.sv ====
`timescale 1ns/1ns

module adcps_sync #(
  parameter int W = 3
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] d,
  output      logic [W-1:0] q
);

  // ----------------------------------------------------------------
  // Two-flop synchroniser per bit
  // ----------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < W; i = i + 1) begin : g_bit
      logic meta_ff;
      logic sync_ff;
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          meta_ff <= 1'b0;
          sync_ff <= 1'b0;
        end else begin
          meta_ff <= d[i];
          sync_ff <= meta_ff;
        end
      end
      assign q[i] = sync_ff;
    end
  endgenerate

endmodule // adcps_sync

// ==== hw/adcps_shdn_ctrl.sv ====
`timescale 1ns/1ns
`include "adcps_map.svh"

module adcps_shdn_ctrl
  import adcps_pkg::*;
(
  input  wire logic  core_clk,
  input  wire logic  rst,
  input  wire logic  link_sclk,
  input  wire logic  cs_n,
  input  wire logic  din,
  output adcps_stat_t stat
);

  // ----------------------------------------------------------------
  // Shift-clock domain: bit count and configuration capture
  // ----------------------------------------------------------------
  // Select high ends the frame; the link clock may stop outside it.
  logic                    lnk_clr;
  logic [4:0]              rise_cnt_ff;
  logic [4:0]              nxt_rise_cnt;
  logic [`ADCPS_CFG_W-1:0] shift_ff;
  logic [`ADCPS_CFG_W-1:0] nxt_shift;
  logic [`ADCPS_CFG_W-1:0] cfg_ff;
  logic                    cfg_vld_ff;
  logic                    cfg_load;
  logic                    shdn_req;
  logic                    shdn_edge;
  logic                    act_tog_ff;
  logic                    sd_tog_ff;

  assign lnk_clr      = rst | cs_n;
  assign nxt_rise_cnt = (rise_cnt_ff == `ADCPS_CNT_MAX) ? rise_cnt_ff
                      : rise_cnt_ff + 5'h01;
  assign nxt_shift    = {shift_ff[`ADCPS_CFG_W-2:0], din};
  assign cfg_load     = (nxt_rise_cnt == `ADCPS_CFG_DONE_CNT);
  assign shdn_req     = cfg_vld_ff &
                        ({cfg_ff[`ADCPS_WL_HI_BIT], cfg_ff[`ADCPS_WL_LO_BIT]}
                         == `ADCPS_WL_SHDN);
  assign shdn_edge    = shdn_req & (rise_cnt_ff == `ADCPS_SHDN_EDGE);

  // Counter restarts each frame
  always_ff @(posedge link_sclk or posedge lnk_clr) begin
    if (lnk_clr) begin
      rise_cnt_ff <= `ADCPS_CNT_RST;
      shift_ff    <= `ADCPS_CFG_RST;
    end else begin
      rise_cnt_ff <= nxt_rise_cnt;
      shift_ff    <= nxt_shift;
    end
  end

  always_ff @(posedge link_sclk or posedge lnk_clr) begin
    if (lnk_clr) begin
      cfg_ff     <= `ADCPS_CFG_RST;
      cfg_vld_ff <= 1'b0;
    end else if (cfg_load) begin
      cfg_ff     <= nxt_shift;
      cfg_vld_ff <= 1'b1;
    end
  end

  // Toggles only see rst: clearing them on select would fake an event
  always_ff @(negedge link_sclk or posedge rst) begin
    if (rst) begin
      act_tog_ff <= 1'b0;
    end else begin
      act_tog_ff <= ~act_tog_ff;
    end
  end

  always_ff @(negedge link_sclk or posedge rst) begin
    if (rst) begin
      sd_tog_ff <= 1'b0;
    end else if (shdn_edge) begin
      sd_tog_ff <= ~sd_tog_ff;
    end
  end

  // ----------------------------------------------------------------
  // Crossing into the core clock
  // ----------------------------------------------------------------
  adcps_link_t lnk_raw;
  adcps_link_t lnk_syn;
  adcps_link_t lnk_prev_ff;

  assign lnk_raw = '{cs_n: cs_n, act_tog: act_tog_ff, sd_tog: sd_tog_ff};

  adcps_sync #(
    .W (3)
  ) u_sync (
    .clk (core_clk),
    .rst (rst),
    .d   (lnk_raw),
    .q   (lnk_syn)
  );

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      lnk_prev_ff <= '0;
    end else begin
      lnk_prev_ff <= lnk_syn;
    end
  end

  logic cs_fall;
  logic act_evt;
  logic sd_evt;
  logic burst_req;

  assign cs_fall   = lnk_prev_ff.cs_n & ~lnk_syn.cs_n;
  assign act_evt   = lnk_prev_ff.act_tog ^ lnk_syn.act_tog;
  assign sd_evt    = lnk_prev_ff.sd_tog ^ lnk_syn.sd_tog;
  // A burst only counts as a request while select is low
  assign burst_req = act_evt & ~lnk_syn.cs_n;

  // ----------------------------------------------------------------
  // Power state machine
  // ----------------------------------------------------------------
  adcps_state_t state_ff;
  adcps_state_t nxt_state;
  logic [7:0]   dcnt_ff;
  logic [7:0]   nxt_dcnt;
  logic         wake_pend_ff;
  logic         nxt_wake_pend;
  logic         dummy_done;
  logic         sleep_wake;
  logic         nxt_conv_req;

  assign dummy_done = (state_ff == st_dummy) & (dcnt_ff == 8'h00);
  assign sleep_wake = (state_ff == st_sleep) & (cs_fall | burst_req);

  always_comb begin
    nxt_state = state_ff;
    nxt_dcnt  = dcnt_ff;
    unique case (state_ff)
      st_run: begin
        if (sd_evt) begin
          nxt_state = st_dummy;
          nxt_dcnt  = `ADCPS_DUMMY_CYC - 8'h01;
        end
      end
      st_dummy: begin
        if (dummy_done) begin
          // Select fell mid-dummy: power straight back up; a fall on
          // this very cycle counts too, or the request would be lost
          nxt_state = (wake_pend_ff | cs_fall) ? st_run : st_sleep;
        end else begin
          nxt_dcnt = dcnt_ff - 8'h01;
        end
      end
      st_sleep: begin
        if (sleep_wake) begin
          nxt_state = st_run;
        end
      end
    endcase
  end

  // Pending wake set wins over its clear at dummy end
  assign nxt_wake_pend = (state_ff == st_dummy) & (cs_fall |
                         (wake_pend_ff & ~dummy_done));
  assign nxt_conv_req  = cs_fall | sleep_wake;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_ff     <= st_run;
      dcnt_ff      <= 8'h00;
      wake_pend_ff <= 1'b0;
    end else begin
      state_ff     <= nxt_state;
      dcnt_ff      <= nxt_dcnt;
      wake_pend_ff <= nxt_wake_pend;
    end
  end

  // ----------------------------------------------------------------
  // Registered outputs
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      stat <= '0;
    end else begin
      stat.power_dn   <= (nxt_state != st_run);
      stat.dummy_busy <= (nxt_state == st_dummy);
      stat.conv_req   <= nxt_conv_req;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_shdn_code_edge: assert property (
    @(negedge link_sclk) disable iff (lnk_clr)
    (rise_cnt_ff == `ADCPS_SHDN_EDGE && cfg_vld_ff &&
     cfg_ff[1:0] == 2'b01) |=> (sd_tog_ff != $past(sd_tog_ff))
  ) else $error("shutdown code not acted on at tenth clock");

  a_no_early_shdn: assert property (
    @(negedge link_sclk) disable iff (rst)
    (rise_cnt_ff != `ADCPS_SHDN_EDGE || cfg_ff[1:0] != 2'b01)
      |=> $stable(sd_tog_ff)
  ) else $error("shutdown toggled off the tenth clock");

  a_shdn_enter: assert property (
    @(posedge core_clk) disable iff (rst)
    (sd_evt && state_ff == st_run) |=> (state_ff == st_dummy)
      ##0 stat.power_dn && stat.dummy_busy
  ) else $error("shutdown event did not start dummy conversion");

  a_dummy_runs: assert property (
    @(posedge core_clk) disable iff (rst)
    $rose(state_ff == st_dummy) |-> (state_ff == st_dummy)[*8]
  ) else $error("dummy conversion cut short");

  a_dummy_to_sleep: assert property (
    @(posedge core_clk) disable iff (rst)
    (dummy_done && !wake_pend_ff && !cs_fall)
      |=> (state_ff == st_sleep) && stat.power_dn && !stat.dummy_busy
  ) else $error("device not asleep after dummy conversion");

  a_pend_wake: assert property (
    @(posedge core_clk) disable iff (rst)
    (dummy_done && (wake_pend_ff || cs_fall))
      |=> (state_ff == st_run) && !stat.power_dn && !stat.dummy_busy
  ) else $error("select fall in dummy conversion did not wake");

  a_sleep_wake_cs: assert property (
    @(posedge core_clk) disable iff (rst)
    (state_ff == st_sleep && cs_fall)
      |=> (state_ff == st_run) && !stat.power_dn && stat.conv_req
  ) else $error("select fall did not wake the device");

  a_sleep_wake_clk: assert property (
    @(posedge core_clk) disable iff (rst)
    (state_ff == st_sleep && act_evt && !lnk_syn.cs_n)
      |=> (state_ff == st_run) && stat.conv_req
  ) else $error("shift clock burst did not wake the device");

  a_sleep_holds: assert property (
    @(posedge core_clk) disable iff (rst)
    (state_ff == st_sleep && !cs_fall && !burst_req)
      |=> (state_ff == st_sleep) && !stat.conv_req
  ) else $error("device left sleep without a request");

endmodule // adcps_shdn_ctrl

// ==== verification/adcps_host.sv ====
`timescale 1ns/1ns

module adcps_host (
  output logic link_sclk,
  output logic cs_n,
  output logic din
);
  realtime t10;

  initial begin
    link_sclk = 1'b0;
    cs_n      = 1'b1;
    din       = 1'b0;
    t10       = 0.0;
  end

  // ------------------------------------------------
  // One transfer; the shift clock stands still outside it
  // ------------------------------------------------
  // Select already low means a new burst, not a select fall
  task automatic frame(input logic [7:0] cfg, input int n, input bit hold);
    int i;
    // Select stays high long enough for the core clock to see it
    #($urandom_range(12, 79));
    cs_n = 1'b0;
    #40;
    for (i = 1; i <= n; i++) begin
      din = (i <= 8) ? cfg[8-i] : 1'($urandom);
      #20 link_sclk = 1'b1;
      #40 link_sclk = 1'b0;
      if (i == 10) t10 = $realtime;
      #20;
    end
    if (!hold) cs_n = 1'b1;
    din = ~din;
  endtask
endmodule // adcps_host

// ==== verification/testbench.sv ====
`timescale 1ns/1ns
`include "adcps_map.svh"

module testbench
  import adcps_pkg::*;
;
  logic        core_clk;
  logic        rst;
  logic        link_sclk;
  logic        cs_n;
  logic        din;
  adcps_stat_t stat;
  logic        pd_q;
  logic [2:0]  ev;
  logic [2:0]  exp_q[$];
  int          fail_count;
  int          checks_done;
  int          busy_cnt;
  int          c;
  int          n_clk;
  bit          keep_sel;
  bit          shdn;

  adcps_shdn_ctrl u_dut (
    .core_clk  (core_clk),
    .rst       (rst),
    .link_sclk (link_sclk),
    .cs_n      (cs_n),
    .din       (din),
    .stat      (stat)
  );

  adcps_host u_host (
    .link_sclk (link_sclk),
    .cs_n      (cs_n),
    .din       (din)
  );

  always #2 core_clk = ~core_clk;

  task automatic bad(input string msg);
    fail_count++;
    $display("wrong value at %0t: %s", $time, msg);
  endtask

  task automatic conclude;
    if (fail_count == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // ------------------------------------------------
  // Monitor: events {power down, wake, request}
  // ------------------------------------------------
  always @(negedge core_clk) begin
    if (rst === 1'b0) begin
      ev = {stat.power_dn & ~pd_q, ~stat.power_dn & pd_q, stat.conv_req};
      if (ev !== 3'h0) begin
        checks_done++;
        if (exp_q.size() == 0 || ev !== exp_q[0]) bad("event");
        if (exp_q.size() != 0) void'(exp_q.pop_front());
      end
      if (ev[2] && ($realtime - u_host.t10 > 40.0)) bad("late");
      if (stat.dummy_busy === 1'b1) begin
        busy_cnt++;
        if (stat.power_dn !== 1'b1) bad("dummy powered");
      end else if (busy_cnt != 0) begin
        checks_done++;
        if (busy_cnt != `ADCPS_DUMMY_CYC) bad("dummy length");
        busy_cnt = 0;
      end
    end
    pd_q = stat.power_dn;
  end

  // Generous bound; the sequence needs about 20 us
  initial begin
    #100000;
    fail_count++;
    conclude();
  end

  initial begin
    core_clk    = 1'b0;
    rst         = 1'b1;
    pd_q        = 1'b0;
    fail_count  = 0;
    checks_done = 0;
    busy_cnt    = 0;
    void'($urandom(85));
    repeat (20) @(posedge core_clk);
    @(negedge core_clk) rst = 1'b0;
    repeat (5) @(negedge core_clk);
    keep_sel    = 1'b0;
    for (c = 0; c < 4; c++) begin
      shdn  = (c == `ADCPS_WL_SHDN);
      n_clk = shdn ? 10 : 8 + $urandom_range(0, 12);
      exp_q.push_back(3'h1);
      if (shdn) exp_q.push_back(3'h4);
      u_host.frame({6'($urandom), 2'(c)}, n_clk, keep_sel);
      #600;
      if (shdn) begin
        n_clk = 9 + $urandom_range(0, 22);
        exp_q.push_back(3'h3);
        u_host.frame({6'($urandom), 2'(c ^ 2)}, n_clk, keep_sel);
        #600;
      end
    end
    // Shift clocks outlast the dummy conversion
    n_clk = 20 + $urandom_range(0, 11);
    exp_q.push_back(3'h1);
    exp_q.push_back(3'h4);
    exp_q.push_back(3'h3);
    u_host.frame({6'($urandom), 2'h1}, n_clk, keep_sel);
    #600;
    // Select falls again while the dummy conversion still runs
    n_clk = 8 + $urandom_range(0, 12);
    exp_q.push_back(3'h1);
    exp_q.push_back(3'h4);
    exp_q.push_back(3'h1);
    exp_q.push_back(3'h2);
    u_host.frame({6'($urandom), 2'h1}, 10, keep_sel);
    u_host.frame({6'($urandom), 2'h0}, n_clk, keep_sel);
    #600;
    // Select held low; the next burst alone wakes it
    keep_sel = 1'b1;
    exp_q.push_back(3'h1);
    exp_q.push_back(3'h4);
    u_host.frame({6'($urandom), 2'h1}, 10, keep_sel);
    #800;
    keep_sel = 1'b0;
    n_clk    = 1 + $urandom_range(0, 12);
    exp_q.push_back(3'h3);
    u_host.frame({6'($urandom), 2'h2}, n_clk, keep_sel);
    #600;
    checks_done++;
    if (exp_q.size() != 0) bad("missing event");
    conclude();
  end
endmodule // testbench
